// *** pmg_gate_if.sv ***
// Carrier between the register side and the source multiplexer.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface pmg_gate_if;
   logic enable;
   logic polarity;
   logic soft_level;
   logic [3:0] source_select;
   logic source_level;
   logic unit_active;
   logic reserved_code;

   modport ctl (
      output enable, polarity, soft_level, source_select,
      input source_level, unit_active, reserved_code
   );
   modport mux (
      input enable, polarity, soft_level, source_select,
      output source_level, unit_active, reserved_code
   );
endinterface : pmg_gate_if
`default_nettype wire

// *** pmg_gate_mux.sv ***
// Source selection and gate law for the modulation gate.
// Assumes source inputs are already synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module pmg_gate_mux
   import pmg_pkg::*;
(
   pmg_gate_if.mux gi, // Control fields in, gate result out
   input wire logic external_modulation_input, // External pin level
   input wire logic capture_compare_unit_2, // Capture-compare unit 2 output
   input wire logic synced_comparator4_output // Synced comparator 4 output
);

   always_comb begin
      case (gi.source_select)
         PMG_SRC_SOFT: gi.source_level = gi.soft_level;
         PMG_SRC_CMP4: gi.source_level = synced_comparator4_output;
         PMG_SRC_CAPTURE_COMPARE_UNIT_2: gi.source_level = capture_compare_unit_2;
         PMG_SRC_EXT: gi.source_level = external_modulation_input;
         // Codes without a known source give a low source level
         default: gi.source_level = 1'b0;
      endcase
   end

   // Soft level reaches the gate only through code 0000 above
   assign gi.unit_active = pmg_active(gi.enable, gi.polarity,
                                      gi.source_level);

   assign gi.reserved_code = (gi.source_select >= PMG_SRC_RSVD_LO);

endmodule : pmg_gate_mux
`default_nettype wire

// *** pmg_pkg.sv ***
// Constants, register map and helpers for the periodic modulation gate.
// Assumes a single 40 MHz clock and an 8-bit register port.
package pmg_pkg;

   localparam int unsigned PMG_DATA_W = 8;
   localparam int unsigned PMG_SRC_W = 4;

   // Register indices on the plain register port
   localparam logic [3:0] PMG_CTRL_OFS = 4'h0;
   localparam logic [3:0] PMG_STAT_OFS = 4'h1;
   localparam logic [3:0] PMG_CNT_OFS = 4'h2;

   // Control register fields
   localparam int unsigned PMG_EN_BIT = 7;
   localparam int unsigned PMG_POL_BIT = 6;
   localparam int unsigned PMG_SOFT_BIT = 5;
   localparam int unsigned PMG_SRC_LSB = 0;
   localparam logic [7:0] PMG_CTRL_RST = 8'h00;
   localparam logic [7:0] PMG_CTRL_WMASK = 8'hef;

   // Status register fields
   localparam int unsigned PMG_ST_ACTIVE_BIT = 0;
   localparam int unsigned PMG_ST_LEVEL_BIT = 1;
   localparam int unsigned PMG_ST_RSVD_NOW_BIT = 2;
   localparam int unsigned PMG_ST_RSVD_SEEN_BIT = 3;

   localparam logic [7:0] PMG_CNT_RST = 8'h00;

   // Source selector codes
   typedef enum logic [3:0] {
      PMG_SRC_SOFT = 4'b0000,
      PMG_SRC_CMP4 = 4'b0100,
      PMG_SRC_CAPTURE_COMPARE_UNIT_2 = 4'b0110,
      PMG_SRC_EXT = 4'b1000,
      PMG_SRC_RSVD_LO = 4'b1100
   } pmg_src_t;

   // Gate law shared by hardware and software sources
   function automatic logic pmg_active(input logic en, input logic pol,
                                        input logic lvl);
      pmg_active = !en || (lvl ^ pol);
   endfunction : pmg_active

   function automatic logic pmg_hit(input logic [3:0] addr,
                                     input logic [3:0] ofs);
      pmg_hit = (addr == ofs);
   endfunction : pmg_hit

endpackage : pmg_pkg

// *** pmg_properties.sv ***
// Port checker for the modulation gate top.
// Assumes clk and rst_b of pmg_top, one domain.
`timescale 1ns/1ps
`default_nettype none
module pmg_properties
   import pmg_pkg::*;
#(
   parameter int unsigned ADDR_W = 4
)
(
   input wire logic clk, // Clock
   input wire logic rst_b, // Reset, active low
   input wire logic [ADDR_W-1:0] reg_addr, // Index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic external_modulation_input, // Pin
   input wire logic capture_compare_unit_2, // Capture unit
   input wire logic synced_comparator4_output, // Comparator
   input wire logic switch_mode_pwm_unit_active, // Gate
   input wire logic modulation_level // Level
);
   logic [7:0] ctl_q;
   logic want;
   // Shadow built from writes so the checker never trusts reads
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_q <= 8'h00;
      end else if (reg_wr && reg_addr == '0) begin
         ctl_q <= reg_wdata & 8'hef;
      end
   end
   always_comb begin
      case (ctl_q[3:0])
         4'h0: want = ctl_q[5];
         4'h8: want = external_modulation_input;
         4'h6: want = capture_compare_unit_2;
         4'h4: want = synced_comparator4_output;
         default: want = 1'b0;
      endcase
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   run_free_a: assert property (
      $past(rst_b && !ctl_q[7]) |-> switch_mode_pwm_unit_active)
      else $error("gated while disabled");
   low_gate_a: assert property (
      $past(rst_b && ctl_q[7] && ctl_q[6])
      |-> switch_mode_pwm_unit_active == !$past(want))
      else $error("low polarity gate wrong");
   high_gate_a: assert property (
      $past(rst_b && ctl_q[7] && !ctl_q[6])
      |-> switch_mode_pwm_unit_active == $past(want))
      else $error("high polarity gate wrong");
   soft_level_a: assert property (
      $past(rst_b && ctl_q[3:0] == 4'h0)
      |-> modulation_level == $past(ctl_q[5]))
      else $error("soft level not used");
   soft_gate_a: assert property (
      $past(rst_b && ctl_q[7] && ctl_q[3:0] == 4'h0)
      |-> switch_mode_pwm_unit_active == $past(ctl_q[5] ^ ctl_q[6]))
      else $error("soft gate wrong");
   hw_level_a: assert property (
      $past(rst_b && ctl_q[3:0] != 4'h0)
      |-> modulation_level == $past(want))
      else $error("hardware source level wrong");
   field_read_a: assert property (
      reg_rd && reg_addr == '0 |=> reg_rdata == $past(ctl_q))
      else $error("control readback wrong");
   cover property (ctl_q[7] && ctl_q[6]);
   cover property (ctl_q == 8'h88 && external_modulation_input);
   cover property (reg_rd && reg_addr == '0);
endmodule : pmg_properties
bind pmg_top pmg_properties #(.ADDR_W(ADDR_W)) pmg_properties_inst (
   .clk(clk),
   .rst_b(rst_b),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .external_modulation_input(external_modulation_input),
   .capture_compare_unit_2(capture_compare_unit_2),
   .synced_comparator4_output(synced_comparator4_output),
   .switch_mode_pwm_unit_active(switch_mode_pwm_unit_active),
   .modulation_level(modulation_level)
);
`default_nettype wire

// *** pmg_top.sv ***
// Periodic modulation gate for one switch-mode PWM unit.
// Assumes a 40 MHz clock, synchronous source inputs and a plain
// register port with read data one cycle after the read strobe.
// Function
// - Enabled, polarity set: unit active only while selected source is low.
// - Enabled, polarity clear: unit active only while selected source is high.
// - Enabled with selector 0000: level comes from the software bit.
// - Software level: bit set active at polarity 0, clear at polarity 1.
// - Software bit ignored by the gate when disabled, and at both outputs when selector is not 0000.
// - Selector is a 4-bit field in control bits 3 to 0.
// - Code 1000 external pin, 0110 capture unit 2, 0100 comparator 4.
`timescale 1ns/1ps
`default_nettype none
module pmg_top
   import pmg_pkg::*;
#(
   parameter int unsigned ADDR_W = 4
)
(
   input wire logic clk, // 40 MHz clock
   input wire logic rst_b, // Asynchronous reset, active low
   input wire logic [ADDR_W-1:0] reg_addr, // Register index
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [7:0] reg_rdata, // Read data, cycle after strobe
   input wire logic external_modulation_input, // External modulation pin
   input wire logic capture_compare_unit_2, // Capture-compare unit 2
   input wire logic synced_comparator4_output, // Synced comparator 4
   output logic switch_mode_pwm_unit_active, // Gate to the PWM unit
   output logic modulation_level // Selected source level
);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rdata;
      logic active;
      logic level;
      logic rsvd_seen;
      logic [7:0] act_count;
   } pmg_state_t;

   localparam pmg_state_t PMG_STATE_RST = '{
      ctrl: PMG_CTRL_RST,
      rdata: 8'h00,
      active: 1'b1,
      level: 1'b0,
      rsvd_seen: 1'b0,
      act_count: PMG_CNT_RST
   };

   pmg_state_t st_q;
   pmg_state_t st_d;

   pmg_gate_if gi ();

   logic [3:0] addr4;
   logic hit_ctrl;
   logic hit_stat;
   logic hit_cnt;
   logic addr_in_map;
   logic [7:0] status_word;

   // Upper index bits must be zero for a hit
   assign addr_in_map = (ADDR_W <= 4) ? 1'b1 :
                        ((reg_addr >> 4) == '0);
   assign addr4 = 4'(reg_addr);
   assign hit_ctrl = addr_in_map && pmg_hit(addr4, PMG_CTRL_OFS);
   assign hit_stat = addr_in_map && pmg_hit(addr4, PMG_STAT_OFS);
   assign hit_cnt = addr_in_map && pmg_hit(addr4, PMG_CNT_OFS);

   // Control fields fan out to the multiplexer
   assign gi.enable = st_q.ctrl[PMG_EN_BIT];
   assign gi.polarity = st_q.ctrl[PMG_POL_BIT];
   assign gi.soft_level = st_q.ctrl[PMG_SOFT_BIT];
   assign gi.source_select =
      st_q.ctrl[PMG_SRC_LSB +: PMG_SRC_W];

   pmg_gate_mux u_mux (
      .gi(gi.mux),
      .external_modulation_input(external_modulation_input),
      .capture_compare_unit_2(capture_compare_unit_2),
      .synced_comparator4_output(synced_comparator4_output)
   );

   always_comb begin
      status_word = 8'h00;
      status_word[PMG_ST_ACTIVE_BIT] = st_q.active;
      status_word[PMG_ST_LEVEL_BIT] = st_q.level;
      status_word[PMG_ST_RSVD_NOW_BIT] = gi.reserved_code;
      status_word[PMG_ST_RSVD_SEEN_BIT] = st_q.rsvd_seen;
   end

   always_comb begin
      st_d = st_q;

      // Control write; bit 4 is not stored and reads as zero
      if (reg_wr && hit_ctrl) begin
         st_d.ctrl = reg_wdata & PMG_CTRL_WMASK;
      end

      // Gate and level are registered so the outputs come from flops
      st_d.active = gi.unit_active;
      st_d.level = gi.source_level;

      // Reserved selector is tolerated but remembered for software;
      // a fresh sighting wins over a clear in the same cycle
      if (reg_wr && hit_stat && reg_wdata[PMG_ST_RSVD_SEEN_BIT]) begin
         st_d.rsvd_seen = 1'b0;
      end
      if (gi.reserved_code) begin
         st_d.rsvd_seen = 1'b1;
      end

      // Count rising edges of the gate; a write clears, and an edge in
      // the same cycle is still counted
      if (reg_wr && hit_cnt) begin
         st_d.act_count = PMG_CNT_RST;
      end
      if (gi.unit_active && !st_q.active) begin
         if (reg_wr && hit_cnt) begin
            st_d.act_count = 8'h01;
         end else begin
            st_d.act_count = st_q.act_count + 8'h01;
         end
      end

      // Read data stands for one cycle only; unmapped reads give zero
      st_d.rdata = 8'h00;
      if (reg_rd) begin
         if (hit_ctrl) begin
            st_d.rdata = st_q.ctrl;
         end else if (hit_stat) begin
            st_d.rdata = status_word;
         end else if (hit_cnt) begin
            st_d.rdata = st_q.act_count;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= PMG_STATE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rdata = st_q.rdata;
   assign switch_mode_pwm_unit_active = st_q.active;
   assign modulation_level = st_q.level;

endmodule : pmg_top
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the modulation gate top.
// Assumes the port checker is bound in from its own file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
   n_errors++; $display("MISMATCH t=%0t got %h exp %h", $time, a, b); \
   end end
module tb;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] srcs = 3'b000; // External, capture, comparator
   logic active;
   logic level;
   int n_errors = 0;
   int tests_run = 0;
   int cycles = 0;
   // Control, sources, then expected active and level
   logic [12:0] rows [10] = '{{8'h00, 3'b100, 2'b10},
      {8'h20, 3'b000, 2'b11}, {8'ha0, 3'b000, 2'b11},
      {8'he0, 3'b000, 2'b01}, {8'hc0, 3'b111, 2'b10},
      {8'h88, 3'b100, 2'b11}, {8'ha8, 3'b011, 2'b00},
      {8'hc6, 3'b010, 2'b01}, {8'hc4, 3'b110, 2'b10},
      {8'h84, 3'b001, 2'b11}};
   always #12.5 clk = ~clk;
   pmg_top pmg_top_inst (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .external_modulation_input(srcs[2]),
      .capture_compare_unit_2(srcs[1]), .synced_comparator4_output(srcs[0]),
      .switch_mode_pwm_unit_active(active), .modulation_level(level));
   task automatic finish_test();
      if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // Strobes are driven on a rising edge so the design samples them
   // cleanly one edge later
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd
   always @(posedge clk) begin
      cycles++;
      if (cycles == 500) begin
         n_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(active, 1'b1)
      rd(4'h0, 8'h00);
      for (int i = 0; i < 10; i++) begin
         wr(4'h0, rows[i][12:5]);
         srcs <= rows[i][4:2];
         repeat (2) @(posedge clk);
         #1;
         `CHK({active, level}, rows[i][1:0])
      end
      rd(4'h1, 8'h03);
      wr(4'h3, 8'h55);
      rd(4'h0, 8'h84);
      @(posedge clk);
      #1;
      `CHK(reg_rdata, 8'h00)
      // Bit 4 set to probe the mask; selector 1011 stays off reserved codes
      wr(4'h0, 8'hfb);
      rd(4'h0, 8'heb);
      `CHK({active, level}, 2'b10)
      rd(4'hf, 8'h00);
      // Mid-run reset from a gated state must free the unit again
      wr(4'h0, 8'he0);
      repeat (2) @(posedge clk);
      #1;
      `CHK({active, level}, 2'b01)
      @(posedge clk);
      rst_b <= 1'b0;
      #1;
      `CHK({active, level, reg_rdata}, {2'b10, 8'h00})
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      `CHK(active, 1'b1)
      rd(4'h0, 8'h00);
      finish_test();
   end
endmodule : tb
`default_nettype wire
